// file: dbs_dram.sv
// dbs_dram: per-bank and whole-device state tracking on the memory side
`timescale 1ns/1ns
module dbs_dram
   import dbs_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // link
   dbs_if.dram link,
   // status
   output dbs_bank_e [NUM_BANKS-1:0] bank_state,
   output logic all_idle,
   output logic dev_busy,
   output logic violation
);

   typedef struct packed {
      dbs_bank_s [NUM_BANKS-1:0] bk;
      dbs_dev_e dv;
      dbs_cnt_t dcnt;
      logic cke_prev;
      logic viol;
      logic all_idle;
      logic busy;
   } dbs_dram_s;

   dbs_dram_s dram_reg;
   dbs_dram_s dram_next;

   // ******************************************************
   // next state
   // ******************************************************
   always_comb begin
      logic valid;
      logic allid;
      logic apbusy;
      logic [1:0] t;
      valid = 1'b0;
      allid = 1'b1;
      apbusy = 1'b0;
      t = link.ba;
      dram_next = dram_reg;
      dram_next.cke_prev = link.cke;
      for (int i = 0; i < NUM_BANKS; i++) begin
         if (dram_reg.bk[i].st != BK_IDLE) allid = 1'b0;
         if (dram_reg.bk[i].st inside {BK_ACTIVATING, BK_RD_AP, BK_WR_AP})
            apbusy = 1'b1;
      end
      // bank timers
      for (int i = 0; i < NUM_BANKS; i++) begin
         if (dram_reg.bk[i].cnt > 5'h01) begin
            dram_next.bk[i].cnt = dram_reg.bk[i].cnt - 5'h01;
         end else begin
            unique case (dram_reg.bk[i].st)
               BK_ACTIVATING: dram_next.bk[i].st = BK_ACTIVE;
               BK_PRECHARGING: dram_next.bk[i].st = BK_IDLE;
               BK_READ: dram_next.bk[i].st = BK_ACTIVE;
               BK_WRITE: dram_next.bk[i].st = BK_ACTIVE;
               BK_RD_AP, BK_WR_AP: begin
                  if (!dram_reg.bk[i].pre) begin
                     dram_next.bk[i].pre = 1'b1;
                     dram_next.bk[i].cnt = PRE_CYC;
                  end else begin
                     dram_next.bk[i].pre = 1'b0;
                     dram_next.bk[i].st = BK_IDLE;
                  end
               end
               BK_IDLE, BK_ACTIVE: begin
               end
            endcase
         end
      end
      // device-wide timer
      if (dram_reg.dv != DV_NORMAL) begin
         if (dram_reg.dcnt > 5'h01) begin
            dram_next.dcnt = dram_reg.dcnt - 5'h01;
         end else begin
            dram_next.dv = DV_NORMAL;
         end
      end
      if (!dram_reg.cke_prev && link.cke) begin
         dram_next.dv = DV_SR_EXIT;
         dram_next.dcnt = SRX_CYC;
      end
      if (dram_reg.cke_prev && link.cke) begin
         if (dram_reg.dv == DV_NORMAL) begin
            valid = 1'b1;
         end else if (link.cmd != CMD_NOP) begin
            dram_next.viol = 1'b1;
         end
      end
      // command decode
      if (valid) begin
         unique case (link.cmd)
            CMD_NOP: begin
            end
            CMD_ACT: begin
               if (dram_reg.bk[t].st == BK_IDLE) begin
                  dram_next.bk[t].st = BK_ACTIVATING;
                  dram_next.bk[t].cnt = ACT_CYC;
               end else begin
                  dram_next.viol = 1'b1;
               end
            end
            CMD_RD, CMD_WR: begin
               if (dram_reg.bk[t].st inside {BK_ACTIVE, BK_READ, BK_WRITE})
               begin
                  dram_next.bk[t].pre = 1'b0;
                  if (link.cmd == CMD_RD) begin
                     dram_next.bk[t].st = link.ap ? BK_RD_AP : BK_READ;
                     dram_next.bk[t].cnt = link.ap ? BURST_CYC
                                                   : RD_BURST_CYC;
                  end else begin
                     dram_next.bk[t].st = link.ap ? BK_WR_AP : BK_WRITE;
                     dram_next.bk[t].cnt = link.ap ? WRAP_ACC_CYC
                                                   : WR_BURST_CYC;
                  end
               end else begin
                  dram_next.viol = 1'b1;
               end
            end
            CMD_PRE: begin
               if (dram_reg.bk[t].st inside {BK_ACTIVATING, BK_RD_AP,
                                             BK_WR_AP}) begin
                  dram_next.viol = 1'b1;
               end else if (dram_reg.bk[t].st != BK_IDLE) begin
                  dram_next.bk[t].st = BK_PRECHARGING;
                  dram_next.bk[t].cnt = PRE_CYC;
               end
            end
            CMD_PREA: begin
               if (apbusy) begin
                  dram_next.viol = 1'b1;
               end else begin
                  dram_next.dv = DV_PREALL;
                  dram_next.dcnt = PRE_CYC;
                  for (int i = 0; i < NUM_BANKS; i++) begin
                     dram_next.bk[i].st = BK_PRECHARGING;
                     dram_next.bk[i].cnt = PRE_CYC;
                  end
               end
            end
            CMD_REF, CMD_LM: begin
               if (!allid) begin
                  dram_next.viol = 1'b1;
               end else if (link.cmd == CMD_REF) begin
                  dram_next.dv = DV_REFRESH;
                  dram_next.dcnt = RFC_CYC;
               end else begin
                  dram_next.dv = DV_MODE;
                  dram_next.dcnt = MRD_CYC;
               end
            end
         endcase
      end
      dram_next.busy = (dram_next.dv != DV_NORMAL);
      dram_next.all_idle = ~dram_next.busy;
      for (int i = 0; i < NUM_BANKS; i++) begin
         if (dram_next.bk[i].st != BK_IDLE) dram_next.all_idle = 1'b0;
      end
   end

   // ******************************************************
   // state register
   // ******************************************************
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         dram_reg <= '0;
      end else begin
         dram_reg <= dram_next;
      end
   end

   // ******************************************************
   // outputs
   // ******************************************************
   genvar g;
   generate
      for (g = 0; g < NUM_BANKS; g++) begin : g_bank
         assign bank_state[g] = dram_reg.bk[g].st;
      end
   endgenerate
   assign all_idle = dram_reg.all_idle;
   assign dev_busy = dram_reg.busy;
   assign violation = dram_reg.viol;

endmodule

// file: dbs_pkg.sv
// dbs_pkg: shared timing constants, commands and state types
package dbs_pkg;

   // ******************************************************
   // clock and timing
   // ******************************************************
   localparam int NUM_BANKS = 4;
   localparam int CLK_PERIOD_NS = 50;
   localparam int PRECHARGE_TIME_NS = 15;
   localparam int ACTIVATE_TO_ACCESS_DELAY_NS = 15;
   localparam int REFRESH_CYCLE_TIME_NS = 105;
   localparam int MODE_SET_DELAY_CK = 2;
   localparam int WRITE_RECOVERY_TIME_NS = 15;
   localparam int WRITE_TO_READ_DELAY_NS = 10;
   localparam int SELF_REFRESH_EXIT_DELAY_NS = 200;
   localparam int COLUMN_ACCESS_LATENCY = 3;
   localparam int BURST_LENGTH = 4;
   localparam int WTR_MIN_CK = 2;

   typedef logic [4:0] dbs_cnt_t;

   // least time to whole cycles, never below one
   function automatic int dbs_ceil(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int WTR_RAW = dbs_ceil(WRITE_TO_READ_DELAY_NS);
   localparam dbs_cnt_t PRE_CYC = dbs_cnt_t'(dbs_ceil(PRECHARGE_TIME_NS));
   localparam dbs_cnt_t ACT_CYC =
      dbs_cnt_t'(dbs_ceil(ACTIVATE_TO_ACCESS_DELAY_NS));
   localparam dbs_cnt_t RFC_CYC =
      dbs_cnt_t'(dbs_ceil(REFRESH_CYCLE_TIME_NS));
   localparam dbs_cnt_t MRD_CYC = dbs_cnt_t'(MODE_SET_DELAY_CK);
   localparam dbs_cnt_t WREC_CYC =
      dbs_cnt_t'(dbs_ceil(WRITE_RECOVERY_TIME_NS));
   localparam dbs_cnt_t SRX_CYC =
      dbs_cnt_t'(dbs_ceil(SELF_REFRESH_EXIT_DELAY_NS));
   localparam dbs_cnt_t WTR_CYC =
      dbs_cnt_t'((WTR_RAW > WTR_MIN_CK) ? WTR_RAW : WTR_MIN_CK);

   // ******************************************************
   // burst and spacing counts
   // ******************************************************
   localparam dbs_cnt_t BURST_CYC = dbs_cnt_t'(BURST_LENGTH / 2);
   localparam dbs_cnt_t RD_BURST_CYC =
      dbs_cnt_t'(COLUMN_ACCESS_LATENCY + BURST_LENGTH / 2);
   localparam dbs_cnt_t WR_BURST_CYC =
      dbs_cnt_t'(COLUMN_ACCESS_LATENCY - 1 + BURST_LENGTH / 2);
   localparam dbs_cnt_t WRAP_ACC_CYC = WR_BURST_CYC + WREC_CYC;
   localparam dbs_cnt_t WR_TO_RD_GAP = WR_BURST_CYC + WTR_CYC;
   localparam dbs_cnt_t RD_TO_WR_GAP = BURST_CYC + 5'h02;
   localparam dbs_cnt_t CNT_ZERO = 5'h00;

   // ******************************************************
   // commands and states
   // ******************************************************
   typedef enum logic [2:0] {
      CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_PREA, CMD_REF, CMD_LM
   } dbs_cmd_e;

   typedef enum logic [2:0] {
      BK_IDLE, BK_ACTIVATING, BK_ACTIVE, BK_READ, BK_WRITE,
      BK_PRECHARGING, BK_RD_AP, BK_WR_AP
   } dbs_bank_e;

   typedef enum logic [2:0] {
      DV_NORMAL, DV_REFRESH, DV_MODE, DV_PREALL, DV_SR_EXIT
   } dbs_dev_e;

   typedef struct packed {
      dbs_bank_e st;
      logic pre;
      dbs_cnt_t cnt;
   } dbs_bank_s;

endpackage

// file: dbs_if.sv
// dbs_if: command link between controller and memory device
`timescale 1ns/1ns
interface dbs_if;
   import dbs_pkg::*;
   logic cke;
   dbs_cmd_e cmd;
   logic [1:0] ba;
   logic ap;

   modport ctrl (output cke, output cmd, output ba, output ap);
   modport dram (input cke, input cmd, input ba, input ap);
endinterface

// file: dbs_ctrl.sv
// dbs_ctrl: controller end that issues only legal bank commands
`timescale 1ns/1ns
module dbs_ctrl
   import dbs_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // link
   dbs_if.ctrl link,
   // user request
   input wire logic req_valid,
   input wire dbs_cmd_e req_cmd,
   input wire logic [1:0] req_bank,
   input wire logic req_ap,
   // user answer
   output logic req_done
);

   typedef struct packed {
      dbs_cnt_t [NUM_BANKS-1:0] bt;
      logic [NUM_BANKS-1:0] open;
      dbs_cnt_t dt;
      dbs_cnt_t rd_gap;
      dbs_cnt_t wr_gap;
      dbs_cnt_t rd_burst;
      dbs_cnt_t any_burst;
      logic cke;
      logic cke_prev;
      dbs_cmd_e cmd;
      logic [1:0] ba;
      logic ap;
      logic done;
   } dbs_ctrl_s;

   dbs_ctrl_s ctrl_reg;
   dbs_ctrl_s ctrl_next;

   // ******************************************************
   // legality and issue
   // ******************************************************
   always_comb begin
      logic base;
      logic free;
      logic allfree;
      logic ok;
      base = 1'b0;
      free = 1'b0;
      allfree = 1'b1;
      ok = 1'b0;
      ctrl_next = ctrl_reg;
      ctrl_next.cke = 1'b1;
      ctrl_next.cke_prev = ctrl_reg.cke;
      ctrl_next.cmd = CMD_NOP;
      ctrl_next.ap = 1'b0;
      ctrl_next.done = 1'b0;
      // count down every timer
      for (int i = 0; i < NUM_BANKS; i++) begin
         if (ctrl_reg.bt[i] != CNT_ZERO) begin
            ctrl_next.bt[i] = ctrl_reg.bt[i] - 5'h01;
            allfree = 1'b0;
         end
      end
      if (ctrl_reg.dt != CNT_ZERO) ctrl_next.dt = ctrl_reg.dt - 5'h01;
      // device waits out its exit delay after clock enable rises
      if (ctrl_reg.cke && !ctrl_reg.cke_prev)
         ctrl_next.dt = SRX_CYC;
      if (ctrl_reg.rd_gap != CNT_ZERO)
         ctrl_next.rd_gap = ctrl_reg.rd_gap - 5'h01;
      if (ctrl_reg.wr_gap != CNT_ZERO)
         ctrl_next.wr_gap = ctrl_reg.wr_gap - 5'h01;
      if (ctrl_reg.rd_burst != CNT_ZERO)
         ctrl_next.rd_burst = ctrl_reg.rd_burst - 5'h01;
      if (ctrl_reg.any_burst != CNT_ZERO)
         ctrl_next.any_burst = ctrl_reg.any_burst - 5'h01;
      // common conditions
      base = req_valid && !ctrl_reg.done &&
             ctrl_reg.cke && ctrl_reg.cke_prev &&
             (ctrl_reg.dt == CNT_ZERO);
      free = (ctrl_reg.bt[req_bank] == CNT_ZERO);
      unique case (req_cmd)
         CMD_NOP: ok = 1'b1;
         CMD_ACT: ok = !ctrl_reg.open[req_bank] && free;
         CMD_RD: ok = ctrl_reg.open[req_bank] && free &&
                      (ctrl_reg.rd_gap == CNT_ZERO);
         CMD_WR: ok = ctrl_reg.open[req_bank] && free &&
                      (ctrl_reg.wr_gap == CNT_ZERO) &&
                      (ctrl_reg.rd_burst == CNT_ZERO);
         CMD_PRE: ok = free;
         CMD_PREA: ok = allfree;
         CMD_REF, CMD_LM: ok = allfree && (ctrl_reg.open == '0) &&
                               (ctrl_reg.any_burst == CNT_ZERO);
      endcase
      if (base && ok) begin
         ctrl_next.cmd = req_cmd;
         ctrl_next.ba = req_bank;
         ctrl_next.ap = req_ap;
         ctrl_next.done = 1'b1;
         unique case (req_cmd)
            CMD_NOP: begin
            end
            CMD_ACT: begin
               ctrl_next.bt[req_bank] = ACT_CYC;
               ctrl_next.open[req_bank] = 1'b1;
            end
            CMD_RD: begin
               ctrl_next.rd_burst = RD_BURST_CYC;
               ctrl_next.any_burst = RD_BURST_CYC;
               ctrl_next.rd_gap = BURST_CYC;
               ctrl_next.wr_gap = RD_TO_WR_GAP;
               if (req_ap) begin
                  ctrl_next.bt[req_bank] = BURST_CYC + PRE_CYC;
                  ctrl_next.open[req_bank] = 1'b0;
               end
            end
            CMD_WR: begin
               ctrl_next.any_burst = WR_BURST_CYC;
               ctrl_next.rd_gap = WR_TO_RD_GAP;
               ctrl_next.wr_gap = BURST_CYC;
               if (req_ap) begin
                  ctrl_next.bt[req_bank] = WRAP_ACC_CYC + PRE_CYC;
                  ctrl_next.open[req_bank] = 1'b0;
               end
            end
            CMD_PRE: begin
               ctrl_next.bt[req_bank] = PRE_CYC;
               ctrl_next.open[req_bank] = 1'b0;
            end
            CMD_PREA: begin
               ctrl_next.dt = PRE_CYC;
               ctrl_next.open = '0;
            end
            CMD_REF: ctrl_next.dt = RFC_CYC;
            CMD_LM: ctrl_next.dt = MRD_CYC;
         endcase
      end
   end

   // ******************************************************
   // state register
   // ******************************************************
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_reg <= '0;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   // ******************************************************
   // outputs
   // ******************************************************
   assign link.cke = ctrl_reg.cke;
   assign link.cmd = ctrl_reg.cmd;
   assign link.ba = ctrl_reg.ba;
   assign link.ap = ctrl_reg.ap;
   assign req_done = ctrl_reg.done;

endmodule

// file: dbs_checker.sv
// dbs_checker: link and device status properties
`timescale 1ns/1ns
module dbs_checker
   import dbs_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // link
   input wire logic cke,
   input wire dbs_cmd_e cmd,
   input wire logic [1:0] ba,
   input wire logic ap,
   // device status
   input wire dbs_bank_e [NUM_BANKS-1:0] bank_state,
   input wire logic dev_busy,
   input wire logic violation
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);

   act_state_a: assert property (
      cmd == CMD_ACT |=> bank_state[$past(ba)] == BK_ACTIVATING
      ##1 bank_state[$past(ba, 2)] == BK_ACTIVE)
      else $error("activate state sequence wrong");
   pre_state_a: assert property (
      cmd == CMD_PRE && bank_state[ba] == BK_ACTIVE
      |=> bank_state[$past(ba)] == BK_PRECHARGING
      ##1 bank_state[$past(ba, 2)] == BK_IDLE)
      else $error("precharge state sequence wrong");
   rdap_state_a: assert property (
      cmd == CMD_RD && ap && ba == 2'h0 && bank_state[0] == BK_ACTIVE
      |=> (bank_state[0] == BK_RD_AP) [*3] ##1 bank_state[0] == BK_IDLE)
      else $error("read auto precharge period wrong");
   wrap_state_a: assert property (
      cmd == CMD_WR && ap && ba == 2'h0 && bank_state[0] == BK_ACTIVE
      |=> (bank_state[0] == BK_WR_AP) [*6] ##1 bank_state[0] == BK_IDLE)
      else $error("write auto precharge period wrong");
   refresh_busy_a: assert property (
      cmd == CMD_REF |=> dev_busy [*3] ##1 (!dev_busy
      && bank_state == 12'h000))
      else $error("refresh busy span wrong");
   mode_busy_a: assert property (
      cmd == CMD_LM |=> dev_busy [*2] ##1 !dev_busy)
      else $error("mode load busy span wrong");
   preall_busy_a: assert property (
      cmd == CMD_PREA |=> dev_busy ##1 (!dev_busy && bank_state == 12'h000))
      else $error("precharge all busy span wrong");
   busy_quiet_a: assert property (
      dev_busy |-> cmd == CMD_NOP)
      else $error("command during device busy");
   ref_idle_a: assert property (
      cmd == CMD_REF || cmd == CMD_LM |-> bank_state == 12'h000)
      else $error("refresh or mode load with bank not idle");
   rd_wr_gap_a: assert property (
      cmd == CMD_RD |=> (cmd != CMD_WR) [*3])
      else $error("write too soon after read");
   wr_rd_gap_a: assert property (
      cmd == CMD_WR |=> (cmd != CMD_RD) [*5])
      else $error("read too soon after write");
   cke_held_a: assert property (
      cmd != CMD_NOP |-> cke && $past(cke))
      else $error("command without clock enable held");
   no_violation_a: assert property (
      !violation)
      else $error("device flagged an illegal command");
endmodule

// file: ddr2_bank_state_command_rules_tb.sv
// ddr2_bank_state_command_rules_tb: controller and device joined on link
`timescale 1ns/1ns
module ddr2_bank_state_command_rules_tb
   import dbs_pkg::*;
;
   logic core_clk, rstn, req_valid, req_ap, req_done;
   logic all_idle, dev_busy, violation;
   dbs_cmd_e req_cmd;
   logic [1:0] req_bank;
   dbs_bank_e [NUM_BANKS-1:0] bank_state;
   int bad_count, compares, cyc, last_cyc, t0;

   dbs_if link();
   dbs_ctrl dbs_ctrl_inst (.core_clk(core_clk), .rstn(rstn), .link(link),
      .req_valid(req_valid), .req_cmd(req_cmd), .req_bank(req_bank),
      .req_ap(req_ap), .req_done(req_done));
   dbs_dram dbs_dram_inst (.core_clk(core_clk), .rstn(rstn), .link(link),
      .bank_state(bank_state), .all_idle(all_idle), .dev_busy(dev_busy),
      .violation(violation));
   dbs_checker dbs_checker_inst (.core_clk(core_clk), .rstn(rstn),
      .cke(link.cke), .cmd(link.cmd), .ba(link.ba), .ap(link.ap),
      .bank_state(bank_state), .dev_busy(dev_busy), .violation(violation));

   // ****************************************
   // clock, cycle count, shared tasks
   // ****************************************
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   always @(posedge core_clk) cyc <= cyc + 1;

   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   // one request, held until done; cmd must show on link with done
   task automatic issue(input dbs_cmd_e c, input logic [1:0] b,
                        input logic a);
      int n;
      step(1);
      req_cmd = c;
      req_bank = b;
      req_ap = a;
      req_valid = 1'b1;
      n = 0;
      do begin
         step(1);
         n++;
      end while (req_done !== 1'b1 && n < 60);
      req_valid = 1'b0;
      last_cyc = cyc;
      check("link cmd", c, link.cmd);
   endtask

   task automatic busy_len(input string what, input int exp);
      int n;
      n = 0;
      step(1);
      while (dev_busy === 1'b1 && n < 20) begin
         n++;
         step(1);
      end
      check(what, exp, n);
   endtask

   task automatic conclude();
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_act_pre();
      issue(CMD_ACT, 2'h1, 1'b0);
      step(1);
      check("b1 activating", BK_ACTIVATING, bank_state[1]);
      step(1);
      check("b1 active", BK_ACTIVE, bank_state[1]);
      issue(CMD_PRE, 2'h1, 1'b0);
      step(1);
      check("b1 precharging", BK_PRECHARGING, bank_state[1]);
      step(1);
      check("b1 idle", BK_IDLE, bank_state[1]);
      $display("test act_pre finished");
   endtask

   task automatic t_auto_pre(input logic wr, input int span);
      issue(CMD_ACT, 2'h0, 1'b0);
      issue(wr ? CMD_WR : CMD_RD, 2'h0, 1'b1);
      step(1);
      check("b0 ap first", wr ? BK_WR_AP : BK_RD_AP, bank_state[0]);
      step(span - 1);
      check("b0 ap last", wr ? BK_WR_AP : BK_RD_AP, bank_state[0]);
      step(1);
      check("b0 ap idle", BK_IDLE, bank_state[0]);
      $display("test auto_pre finished");
   endtask

   task automatic t_gaps();
      int wtr;
      wtr = (WRITE_TO_READ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      wtr = (wtr > 2) ? wtr : 2;
      issue(CMD_ACT, 2'h0, 1'b0);
      issue(CMD_ACT, 2'h1, 1'b0);
      issue(CMD_ACT, 2'h2, 1'b0);
      issue(CMD_RD, 2'h0, 1'b1);
      t0 = last_cyc;
      issue(CMD_WR, 2'h1, 1'b0);
      check("rdap to wr", 1, last_cyc - t0 >= BURST_LENGTH / 2 + 2);
      t0 = last_cyc;
      issue(CMD_RD, 2'h2, 1'b0);
      check("wr to rd", 1, last_cyc - t0 >= COLUMN_ACCESS_LATENCY - 1
         + BURST_LENGTH / 2 + wtr);
      t0 = last_cyc;
      issue(CMD_WR, 2'h2, 1'b0);
      check("rd to wr", 1, last_cyc - t0 >= COLUMN_ACCESS_LATENCY
         + BURST_LENGTH / 2);
      issue(CMD_WR, 2'h1, 1'b1);
      t0 = last_cyc;
      issue(CMD_ACT, 2'h0, 1'b0);
      check("wrap to act", 2, last_cyc - t0);
      issue(CMD_RD, 2'h2, 1'b0);
      check("wrap to rd", 1, last_cyc - t0 >= COLUMN_ACCESS_LATENCY - 1
         + BURST_LENGTH / 2 + wtr);
      $display("test gaps finished");
   endtask

   task automatic t_reset();
      step(1);
      rstn = 1'b0;
      step(2);
      rstn = 1'b1;
      t0 = cyc;
      issue(CMD_ACT, 2'h0, 1'b0);
      check("exit wait", 1, last_cyc - t0 >= 2 + (SELF_REFRESH_EXIT_DELAY_NS
         + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
      step(1);
      check("exit no violation", 0, violation);
      check("exit b0 activating", BK_ACTIVATING, bank_state[0]);
      $display("test reset finished");
   endtask

   task automatic t_device();
      issue(CMD_PREA, 2'h0, 1'b0);
      busy_len("prea busy", (PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1)
         / CLK_PERIOD_NS);
      check("banks idle", 12'h000, bank_state);
      issue(CMD_REF, 2'h0, 1'b0);
      busy_len("ref busy", (REFRESH_CYCLE_TIME_NS + CLK_PERIOD_NS - 1)
         / CLK_PERIOD_NS);
      issue(CMD_LM, 2'h0, 1'b0);
      busy_len("lm busy", MODE_SET_DELAY_CK);
      step(1);
      check("all idle", 1, all_idle);
      check("no violation", 0, violation);
      $display("test device finished");
   endtask

   // ****************************************
   // main sequence and watchdog
   // ****************************************
   initial begin
      rstn = 1'b0;
      req_valid = 1'b0;
      req_cmd = CMD_NOP;
      req_bank = 2'h0;
      req_ap = 1'b0;
      bad_count = 0;
      compares = 0;
      cyc = 0;
      repeat (5) @(posedge core_clk);
      #1;
      rstn = 1'b1;
      step(10);
      t_act_pre();
      t_auto_pre(1'b0, 3);
      t_auto_pre(1'b1, 6);
      t_gaps();
      t_reset();
      t_device();
      conclude();
   end

   initial begin
      #(CLK_PERIOD_NS * 3000);
      bad_count++;
      conclude();
   end
endmodule
